// [rtl/iadp_top.sv]
`timescale 1ns/1ps

module iadp_top
  import iadp_pkg::*;
#(
  parameter int SET_W = 32,
  parameter int PIN_W = 16
) (
  input  wire logic                         clk_in,
  input  wire logic                         rst_in,
  input  wire iadp_host_req_t               host_req_in,
  output logic                              host_ack_out,
  output logic [31:0]                       host_rdata_out,
  output iadp_rom_bus_t                     rom_bus_out,
  input  wire logic [7:0]                   rom_data_in,
  output logic [7:0]                        cfg_index_out,
  output logic                              cfg_wr_out,
  output logic [7:0]                        cfg_wdata_out,
  input  wire logic [7:0]                   cfg_rdata_in,
  input  wire logic [CTL_SEL_W-1:0]         diag_sel_pins_in,
  input  wire logic [(SET_W<<CTL_SEL_W)-1:0] diag_sets_in,
  output logic [PIN_W-1:0]                  diag_pins_out
);

  ////////////////////////////////////////////////////////////////////////////
  // decode

  function automatic logic hit(input iadp_host_req_t req,
                               input logic [7:0]     ofs,
                               input logic           windowed);
    hit = (req.addr == ofs) && (!windowed || req.window == ROM_WINDOW);
  endfunction : hit

  iadp_rom_state_t state_q;
  iadp_rom_state_t state_d;
  logic            take;

  // new requests are only taken while no rom cycle is running
  assign take = (state_q == ST_IDLE) && (host_req_in.rd || host_req_in.wr);

  ////////////////////////////////////////////////////////////////////////////
  // registers and debug view

  logic [ROM_ADDR_BITS-1:0] addr_q;
  logic [ROM_ADDR_BITS-1:0] addr_d;
  logic [7:0]               idx_q;
  logic [7:0]               idx_d;
  logic [15:0]              ctl_q;
  logic [15:0]              ctl_d;
  logic [SET_W-1:0]         view_q;
  logic [SET_W-1:0]         view_d;
  logic [PIN_W-1:0]         pins_q;
  logic [PIN_W-1:0]         pins_d;
  logic                     cfg_wr_q;
  logic                     cfg_wr_d;
  logic [7:0]               cfg_wdata_q;
  logic [7:0]               cfg_wdata_d;
  logic [CTL_SEL_W-1:0]     eff_sel;

  always_comb begin
    addr_d      = addr_q;
    idx_d       = idx_q;
    ctl_d       = ctl_q;
    cfg_wr_d    = 1'b0;
    cfg_wdata_d = cfg_wdata_q;
    if (take && host_req_in.wr) begin
      if (hit(host_req_in, ROM_ADDR_OFS, 1'b1)) begin
        addr_d = host_req_in.wdata[ROM_ADDR_BITS-1:0];
      end
      if (hit(host_req_in, CFG_IDX_OFS, 1'b0)) begin
        idx_d = host_req_in.wdata[7:0];
      end
      if (hit(host_req_in, CFG_DATA_OFS, 1'b0)) begin
        cfg_wr_d    = 1'b1;
        cfg_wdata_d = host_req_in.wdata[7:0];
      end
      if (hit(host_req_in, VIEW_CTL_OFS, 1'b0)) begin
        ctl_d = host_req_in.wdata[15:0] & CTL_WMASK;
      end
    end
    // pins choose the set unless the override bit hands it to the field
    eff_sel = ctl_q[CTL_OVR_BIT] ? ctl_q[CTL_SEL_LSB +: CTL_SEL_W]
                                 : diag_sel_pins_in;
    view_d  = diag_sets_in[SET_W*eff_sel +: SET_W];
    pins_d  = view_d[PIN_W-1:0];
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      addr_q      <= ADDR_RESET[ROM_ADDR_BITS-1:0];
      idx_q       <= IDX_RESET;
      ctl_q       <= CTL_RESET;
      view_q      <= '0;
      pins_q      <= '0;
      cfg_wr_q    <= 1'b0;
      cfg_wdata_q <= 8'h00;
    end else begin
      addr_q      <= addr_d;
      idx_q       <= idx_d;
      ctl_q       <= ctl_d;
      view_q      <= view_d;
      pins_q      <= pins_d;
      cfg_wr_q    <= cfg_wr_d;
      cfg_wdata_q <= cfg_wdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // rom cycle engine and host answer

  logic [7:0]    cnt_q;
  logic [7:0]    cnt_d;
  iadp_rom_bus_t rom_q;
  iadp_rom_bus_t rom_d;
  logic          ack_q;
  logic          ack_d;
  logic [31:0]   rdata_q;
  logic [31:0]   rdata_d;

  always_comb begin
    state_d     = state_q;
    cnt_d       = cnt_q;
    rom_d       = rom_q;
    rom_d.addr  = addr_d;
    ack_d       = 1'b0;
    rdata_d     = rdata_q;
    case (state_q)
      ST_IDLE: begin
        if (take && hit(host_req_in, ROM_DATA_OFS, 1'b1)) begin
          rom_d.ce_n = 1'b0;
          if (host_req_in.rd) begin
            state_d    = ST_RD;
            cnt_d      = ROM_RD_CYC - 8'h01;
            rom_d.oe_n = 1'b0;
          end else begin
            state_d       = ST_WR;
            cnt_d         = ROM_WR_CYC - 8'h01;
            rom_d.we_n    = 1'b0;
            rom_d.data_oe = 1'b1;
            rom_d.wdata   = host_req_in.wdata[7:0];
          end
        end else if (take) begin
          ack_d   = 1'b1;
          rdata_d = 32'h0000_0000;
          if (host_req_in.rd) begin
            if (hit(host_req_in, ROM_ADDR_OFS, 1'b1)) begin
              rdata_d = {{(32-ROM_ADDR_BITS){1'b0}}, addr_q};
            end else if (hit(host_req_in, CFG_IDX_OFS, 1'b0)) begin
              rdata_d = {24'h00_0000, idx_q};
            end else if (hit(host_req_in, CFG_DATA_OFS, 1'b0)) begin
              rdata_d = {24'h00_0000, cfg_rdata_in};
            end else if (hit(host_req_in, VIEW_RB_OFS, 1'b0)) begin
              rdata_d = view_q;
            end else if (hit(host_req_in, VIEW_CTL_OFS, 1'b0)) begin
              rdata_d = {16'h0000, ctl_q};
            end
          end
        end
      end
      ST_RD: begin
        if (cnt_q == 8'h00) begin
          state_d    = ST_IDLE;
          rom_d      = ROM_BUS_IDLE;
          rom_d.addr = addr_d;
          ack_d      = 1'b1;
          rdata_d    = {24'h00_0000, rom_data_in};
        end else begin
          cnt_d = cnt_q - 8'h01;
        end
      end
      ST_WR: begin
        // release the strobe, keep data and select for one hold cycle
        if (cnt_q == 8'h00) begin
          state_d    = ST_HOLD;
          rom_d.we_n = 1'b1;
        end else begin
          cnt_d = cnt_q - 8'h01;
        end
      end
      ST_HOLD: begin
        state_d    = ST_IDLE;
        rom_d      = ROM_BUS_IDLE;
        rom_d.addr = addr_d;
        ack_d      = 1'b1;
        rdata_d    = 32'h0000_0000;
      end
      default: begin
        state_d = ST_IDLE;
        rom_d   = ROM_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q <= ST_IDLE;
      cnt_q   <= 8'h00;
      rom_q   <= ROM_BUS_IDLE;
      ack_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      rom_q   <= rom_d;
      ack_q   <= ack_d;
      rdata_q <= rdata_d;
    end
  end

  assign host_ack_out   = ack_q;
  assign host_rdata_out = rdata_q;
  assign rom_bus_out    = rom_q;
  assign cfg_index_out  = idx_q;
  assign cfg_wr_out     = cfg_wr_q;
  assign cfg_wdata_out  = cfg_wdata_q;
  assign diag_pins_out  = pins_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  logic rom_rd_go;
  logic rom_wr_go;
  assign rom_rd_go = take && host_req_in.rd && hit(host_req_in, ROM_DATA_OFS, 1'b1);
  assign rom_wr_go = take && host_req_in.wr && hit(host_req_in, ROM_DATA_OFS, 1'b1);

  chk_addr_write: assert property (@(posedge clk_in) disable iff (rst_in)
    take && host_req_in.wr && hit(host_req_in, ROM_ADDR_OFS, 1'b1)
    |=> addr_q == $past(host_req_in.wdata[ROM_ADDR_BITS-1:0]))
    else $error("rom address register did not take write");

  chk_rom_read_ack: assert property (@(posedge clk_in) disable iff (rst_in)
    rom_rd_go |-> ##13
    (host_ack_out && rom_bus_out.oe_n && host_rdata_out[7:0] == $past(rom_data_in)))
    else $error("rom read not acked after full access time");

  chk_rom_read_hold: assert property (@(posedge clk_in) disable iff (rst_in)
    state_q == ST_RD
    |-> !rom_bus_out.ce_n && !rom_bus_out.oe_n && !host_ack_out)
    else $error("rom read strobe dropped or early ack");

  chk_rom_write_pulse: assert property (@(posedge clk_in) disable iff (rst_in)
    rom_wr_go |-> ##11
    (rom_bus_out.we_n && rom_bus_out.data_oe && !host_ack_out) ##1 host_ack_out)
    else $error("rom program strobe or ack timing wrong");

  chk_rom_write_hold: assert property (@(posedge clk_in) disable iff (rst_in)
    state_q == ST_WR
    |-> !rom_bus_out.ce_n && !rom_bus_out.we_n && rom_bus_out.data_oe && !host_ack_out)
    else $error("rom program strobe dropped or early ack");

  chk_rom_addr_follow: assert property (@(posedge clk_in) disable iff (rst_in)
    rom_bus_out.addr == addr_q)
    else $error("rom address pins differ from address register");

  chk_rom_idle_bus: assert property (@(posedge clk_in) disable iff (rst_in)
    state_q == ST_IDLE |-> rom_bus_out.ce_n && rom_bus_out.we_n && !rom_bus_out.data_oe)
    else $error("rom bus active while engine idle");

  chk_idx_load: assert property (@(posedge clk_in) disable iff (rst_in)
    take && host_req_in.wr && hit(host_req_in, CFG_IDX_OFS, 1'b0)
    |=> cfg_index_out == $past(host_req_in.wdata[7:0]))
    else $error("config index not loaded");

  chk_cfg_read: assert property (@(posedge clk_in) disable iff (rst_in)
    take && host_req_in.rd && hit(host_req_in, CFG_DATA_OFS, 1'b0)
    |=> host_ack_out && host_rdata_out == {24'h00_0000, $past(cfg_rdata_in)})
    else $error("config data read mismatch");

  chk_cfg_write: assert property (@(posedge clk_in) disable iff (rst_in)
    take && host_req_in.wr && hit(host_req_in, CFG_DATA_OFS, 1'b0)
    |=> cfg_wr_out && host_ack_out && cfg_wdata_out == $past(host_req_in.wdata[7:0])
    ##1 !cfg_wr_out)
    else $error("config data write not issued once");

  chk_ctl_unused: assert property (@(posedge clk_in) disable iff (rst_in)
    ctl_q[14:5] == 10'h000)
    else $error("debug control unused bits not zero");

  chk_sel_pins: assert property (@(posedge clk_in) disable iff (rst_in)
    !ctl_q[CTL_OVR_BIT] ##1 !$past(ctl_q[CTL_OVR_BIT])
    |-> view_q == $past(diag_sets_in[SET_W*diag_sel_pins_in +: SET_W]))
    else $error("debug view ignored select pins");

  chk_sel_override: assert property (@(posedge clk_in) disable iff (rst_in)
    ctl_q[CTL_OVR_BIT] |=> view_q == $past(diag_sets_in[SET_W*ctl_q[4:0] +: SET_W])
    && diag_pins_out == view_q[PIN_W-1:0])
    else $error("debug override select not applied");

endmodule : iadp_top

// [rtl/iadp_pkg.sv]
package iadp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets on the host I/O port
  localparam logic [7:0] ROM_ADDR_OFS = 8'h04;
  localparam logic [7:0] ROM_DATA_OFS = 8'h08;
  localparam logic [7:0] CFG_IDX_OFS  = 8'h44;
  localparam logic [7:0] CFG_DATA_OFS = 8'h48;
  localparam logic [7:0] VIEW_RB_OFS  = 8'h70;
  localparam logic [7:0] VIEW_CTL_OFS = 8'h74;
  // boot rom registers only decode in this window
  localparam logic [2:0] ROM_WINDOW   = 3'h0;

  ////////////////////////////////////////////////////////////////////////////
  // field layouts and reset values
  localparam int           ROM_ADDR_BITS = 17;
  localparam int           CTL_SEL_LSB   = 0;
  localparam int           CTL_SEL_W     = 5;
  localparam int           CTL_OVR_BIT   = 15;
  localparam logic [15:0]  CTL_RESET     = 16'h0000;
  localparam logic [15:0]  CTL_WMASK     = 16'h801f;
  localparam logic [31:0]  ADDR_RESET    = 32'h0000_0000;
  localparam logic [7:0]   IDX_RESET     = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // timing: rom access and program pulse, rounded up to whole cycles
  localparam int          CLK_PERIOD_NS = 10;
  localparam int          ROM_RD_NS     = 120;
  localparam int          ROM_WR_NS     = 100;
  localparam logic [7:0]  ROM_RD_CYC    =
    8'((ROM_RD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0]  ROM_WR_CYC    =
    8'((ROM_WR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  ////////////////////////////////////////////////////////////////////////////
  // carriers
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [2:0]  window;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } iadp_host_req_t;

  typedef struct packed {
    logic                     ce_n;
    logic                     oe_n;
    logic                     we_n;
    logic                     data_oe;
    logic [ROM_ADDR_BITS-1:0] addr;
    logic [7:0]               wdata;
  } iadp_rom_bus_t;

  localparam iadp_rom_bus_t ROM_BUS_IDLE = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
                                             data_oe: 1'b0, addr: '0, wdata: 8'h00};

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_RD   = 4'h2,
    ST_WR   = 4'h4,
    ST_HOLD = 4'h8
  } iadp_rom_state_t;

endpackage : iadp_pkg

// [dv/iadp_rom_model.sv]
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
// paged flash rom seen from its pins
module iadp_rom_model
  import iadp_pkg::*;
(
  input  wire iadp_rom_bus_t rom_bus_in,
  output logic [7:0]         rom_data_out
);
  logic [7:0] mem [0:(1<<ROM_ADDR_BITS)-1];
  logic [7:0] held;
  logic       drive;

  initial begin
    for (int a = 0; a < (1 << ROM_ADDR_BITS); a++) begin
      mem[a] = 8'(a) ^ 8'h5a;
    end
    held = 8'h00;
  end

  assign drive = !rom_bus_in.ce_n && !rom_bus_in.oe_n && !rom_bus_in.data_oe;

  // released bus shows the inverse of the last byte
  always @* begin
    if (drive) begin
      held = mem[rom_bus_in.addr];
    end
    rom_data_out = drive ? held : ~held;
  end

  // byte programmed at the end of the write pulse
  always @(posedge rom_bus_in.we_n) begin
    if (!rom_bus_in.ce_n) begin
      mem[rom_bus_in.addr] <= rom_bus_in.wdata;
    end
  end
endmodule : iadp_rom_model

// [dv/tb_indirect_access_and_debug_ports.sv]
`timescale 1ns/1ps
module tb_indirect_access_and_debug_ports
  import iadp_pkg::*;
;
  typedef struct {
    logic        wr;
    logic [2:0]  w;
    logic [7:0]  a;
    logic [31:0] d;
    logic [31:0] e;
  } iadp_row_t;

  logic           clk_in = 1'b0;
  logic           rst_in = 1'b1;
  iadp_host_req_t host_req_in = '0;
  logic           ack;
  logic [31:0]    rdata;
  iadp_rom_bus_t  rom_bus;
  logic [7:0]     rom_data;
  logic [7:0]     cfg_index;
  logic           cfg_wr;
  logic [7:0]     cfg_wdata;
  logic [7:0]     cfg_rdata;
  logic [4:0]     diag_sel_pins_in = 5'h00;
  logic [1023:0]  diag_sets_in;
  logic [15:0]    diag_pins;
  logic [7:0]     cfg_mem [256];
  logic [31:0]    q;
  int             n;
  int             error_cnt = 0;
  int             checks_done = 0;
  iadp_row_t      rows [9] = '{
    '{1, 0, 8'h04, 32'hffff_ffff, 0}, '{0, 0, 8'h04, 0, 32'h0001_ffff},
    '{0, 1, 8'h04, 0, 0},             '{1, 0, 8'h74, 32'hffff_ffff, 0},
    '{0, 0, 8'h74, 0, 32'h0000_801f}, '{1, 0, 8'h74, 0, 0},
    '{1, 0, 8'h44, 32'h0000_01fe, 0}, '{0, 0, 8'h44, 0, 32'h0000_00fe},
    '{0, 0, 8'h48, 0, 32'h0000_0001}};

  always #5 clk_in = ~clk_in;

  iadp_top i_iadp_top (
    .clk_in(clk_in), .rst_in(rst_in), .host_req_in(host_req_in),
    .host_ack_out(ack), .host_rdata_out(rdata), .rom_bus_out(rom_bus),
    .rom_data_in(rom_data), .cfg_index_out(cfg_index), .cfg_wr_out(cfg_wr),
    .cfg_wdata_out(cfg_wdata), .cfg_rdata_in(cfg_rdata),
    .diag_sel_pins_in(diag_sel_pins_in), .diag_sets_in(diag_sets_in),
    .diag_pins_out(diag_pins));

  iadp_rom_model i_iadp_rom_model (.rom_bus_in(rom_bus), .rom_data_out(rom_data));

  ////////////////////////////////////////////////////////////////////////////
  // config space stand-in
  assign cfg_rdata = cfg_mem[cfg_index];
  always @(posedge clk_in) if (cfg_wr) cfg_mem[cfg_index] <= cfg_wdata;

  function automatic logic [31:0] setv(int k);
    return {8'h5a, 8'(k), 8'hc3, 8'(k)};
  endfunction : setv

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      error_cnt++;
      $display("BAD %0t: got %h want %h", $time, s, e);
    end
  endtask : chk

  // one pulse request, then wait for the answer; n counts cycles to it
  task automatic acc(input logic wr, input logic [2:0] w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] rq, output int cn);
    @(posedge clk_in);
    host_req_in <= '{rd: !wr, wr: wr, window: w, addr: a, wdata: d};
    @(posedge clk_in);
    host_req_in <= '0;
    cn = 1;
    #1;
    while (ack !== 1'b1 && cn < 40) begin
      @(posedge clk_in);
      #1;
      cn++;
    end
    if (ack !== 1'b1) chk({31'h0, ack}, 32'h1);
    rq = rdata;
  endtask : acc

  task automatic tally_and_finish();
    if (error_cnt == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : tally_and_finish

  initial begin
    #300000;
    error_cnt++;
    tally_and_finish();
  end

  initial begin
    for (int k = 0; k < 32; k++) diag_sets_in[32*k+:32] = setv(k);
    for (int i = 0; i < 256; i++) cfg_mem[i] = ~8'(i);
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b0;
    foreach (rows[i]) begin
      acc(rows[i].wr, rows[i].w, rows[i].a, rows[i].d, q, n);
      if (!rows[i].wr) chk(q, rows[i].e);
    end
    // mid-run reset clears the control register
    acc(1, 0, 8'h74, 32'h8005, q, n);
    @(posedge clk_in) rst_in <= 1'b1;
    @(posedge clk_in) rst_in <= 1'b0;
    acc(0, 0, 8'h74, 0, q, n);
    chk(q, 0);
    // one whole page programmed, then ends read back
    for (int b = 0; b < 64; b++) begin
      acc(1, 0, 8'h04, 32'h0001_2340 + 32'(b), q, n);
      acc(1, 0, 8'h08, 32'(b) ^ 32'h3c, q, n);
    end
    chk(32'(n), 32'd12);
    chk({15'h0, rom_bus.addr}, 32'h0001_237f);
    for (int b = 0; b < 64; b += 63) begin
      acc(1, 0, 8'h04, 32'h0001_2340 + 32'(b), q, n);
      acc(0, 0, 8'h08, 0, q, n);
      chk(q, 32'(b) ^ 32'h3c);
      chk(32'(n), 32'd13);
    end
    // config back door
    acc(1, 0, 8'h44, 32'h80, q, n);
    acc(1, 0, 8'h48, 32'hff77, q, n);
    acc(0, 0, 8'h48, 0, q, n);
    chk({24'h0, cfg_mem[8'h80]}, 32'h77);
    chk(q, 32'h77);
    // debug view: pins select, then override
    @(posedge clk_in) diag_sel_pins_in <= 5'd7;
    acc(1, 0, 8'h74, 32'h0003, q, n);
    acc(0, 0, 8'h70, 0, q, n);
    chk(q, setv(7));
    chk({16'h0, diag_pins}, setv(7) & 32'hffff);
    acc(1, 0, 8'h74, 32'h801f, q, n);
    acc(1, 0, 8'h70, 0, q, n);
    acc(0, 0, 8'h70, 0, q, n);
    chk(q, setv(31));
    chk({16'h0, diag_pins}, setv(31) & 32'hffff);
    tally_and_finish();
  end
endmodule : tb_indirect_access_and_debug_ports
